// ===== ucr_pkg.sv
// ucr_pkg: register map, field positions, reset values, modes and types
// for the usart clock-mode and receive-buffer block.
// assumes a 32-bit apb register bus and a single 100 MHz system clock.
package ucr_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFF_CTRL_STATUS_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_STATUS_B = 8'h04;
  localparam logic [7:0] OFF_CTRL_STATUS_C = 8'h08;
  localparam logic [7:0] OFF_BAUD_LO = 8'h0C;
  localparam logic [7:0] OFF_BAUD_HI = 8'h10;
  localparam logic [7:0] OFF_SERIAL_DATA = 8'h14;
  localparam logic [7:0] OFF_INT_STATUS = 8'h18;
  localparam logic [7:0] OFF_INT_MASK = 8'h1C;

  // ==========================================================
  // field positions
  localparam int BIT_RX_COMPLETE = 7;
  localparam int BIT_FRAME_ERROR = 4;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_DOUBLE_SPEED = 1;
  localparam int BIT_CHAR_SIZE_TOP = 2;
  localparam int BIT_NINTH_RX = 1;
  localparam int BIT_SYNC_SELECT = 6;
  localparam int BIT_XCK_DIRECTION = 0;
  localparam int BIT_EV_RX_DONE = 0;
  localparam int BIT_EV_OVERRUN = 1;
  localparam int BIT_EV_FRAME_ERR = 2;

  // ==========================================================
  // widths and reset values
  localparam int BAUD_W = 12;
  localparam int EV_W = 3;
  localparam logic [BAUD_W-1:0] RST_BAUD = 12'h000;
  localparam logic [EV_W-1:0] RST_INT_MASK = 3'h0;
  localparam logic RST_CTRL_BIT = 1'b0;

  // ==========================================================
  // recovery state counts per bit for each clock mode
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] SPB_SYNC = 5'h02;
  localparam int QUEUE_DEPTH = 2;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  typedef struct packed {
    logic frame_err;
    logic overrun;
    logic ninth;
    logic [7:0] data;
  } ucr_entry_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_STOP = 3'b011,
    ST_PARK = 3'b100
  } ucr_rx_state_t;

endpackage

// ===== ucr_rx_queue.sv
// ucr_rx_queue: two-entry circular receive store, oldest entry out first.
// assumes push is never raised while full; the head is a register and
// follows the queue one cycle later.
`timescale 1ns/1ps
module ucr_rx_queue (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // write side
  input wire logic push_i,
  input wire ucr_pkg::ucr_entry_t push_entry_i,
  // read side
  input wire logic pop_i,
  output ucr_pkg::ucr_entry_t head_o,
  output logic head_valid_o,
  output logic full_o,
  output logic [1:0] count_o
);

  ucr_pkg::ucr_entry_t mem [ucr_pkg::QUEUE_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic do_pop;

  assign do_pop = pop_i && (count_o != 2'h0);

  // ==========================================================
  // storage and pointers
  // [R1] circular fifo order
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count_o <= 2'h0;
      mem[0] <= '0;
      mem[1] <= '0;
    end else begin
      if (push_i) begin
        mem[wr_ptr] <= push_entry_i;
        wr_ptr <= ~wr_ptr;
      end
      if (do_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count_o <= 2'(count_o + {1'b0, push_i} - {1'b0, do_pop});
    end
  end

  // [R16] head advances after pop
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      head_o <= '0;
      head_valid_o <= 1'b0;
      full_o <= 1'b0;
    end else begin
      head_o <= mem[rd_ptr];
      head_valid_o <= (count_o != 2'h0);
      full_o <= (2'(count_o + {1'b0, push_i} - {1'b0, do_pop}) == 2'h2);
    end
  end

  // [R5] no push into a full queue
  AST_NO_PUSH_FULL: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !(push_i && count_o == 2'h2)) // [R5]
    else $error("push into full receive queue");

endmodule

// ===== ucr_serial_node.sv
// ucr_serial_node: remote serial node driving the receive line.
// assumes its tasks run in a process synchronised to ref_clk_i.
`timescale 1ns/1ps
module ucr_serial_node (
  // clocks
  input wire logic ref_clk_i,
  input wire logic xck_i,
  // line outputs
  output logic rxd_o,
  output logic xck_o
);
  // ==========================================================
  // line drive
  initial begin
    rxd_o = 1'b1;
    xck_o = 1'b0;
  end

  // mode 0 async, 1 node makes the clock, 2 follows the device clock
  // own clock stands low between frames, like a real slave link
  task automatic slot(input logic b, input int mode, input int half);
    if (mode == 2) begin
      @(posedge xck_i);
      @(posedge ref_clk_i);
      rxd_o <= b;
    end else begin
      rxd_o <= b;
      xck_o <= (mode == 1);
      repeat (half) @(posedge ref_clk_i);
      xck_o <= 1'b0;
      repeat (half) @(posedge ref_clk_i);
    end
  endtask

  // lsb first, one stop bit, then one idle bit
  task automatic send(input logic [8:0] ch, input int nb, input logic stop, input int mode,
                      input int half);
    @(posedge ref_clk_i);
    slot(1'b0, mode, half);
    for (int i = 0; i < nb; i++) begin
      slot(ch[i], mode, half);
    end
    slot(stop, mode, half);
    slot(1'b1, mode, half);
  endtask
endmodule

// ===== ucr_usart_clk_rx.sv
// ucr_usart_clk_rx: usart clock generator (four modes) and receiver with
// a two-entry receive queue plus the shift register as a third level.
// assumes an apb master on ref_clk_i; rxd and xck pins are asynchronous.
//
// Functional notes
// [R1] The two receive holding registers form a fifo delivering characters in arrival order.
// [R2] Software reads the data port once per character, since each read advances the queue.
// [R3] Frame error, overrun and ninth bit are stored with each character and advance with it.
// [R4] Software reads the status bits before the data port or loses that character's status.
// [R5] With both holding registers full the shift register keeps the finished character.
// [R6] A parked character stays only until a new start bit arrives while the queue is full.
// [R7] Four clock modes exist and supply base ticks to transmitter and receiver.
// [R8] The sync-select bit in control register C picks synchronous operation when one.
// [R9] The double-speed bit in control register A acts only in asynchronous mode.
// [R10] In synchronous mode the transfer clock direction picks master (out) or slave (in).
// [R11] The transfer clock pin is used only in synchronous mode.
// [R12] The char-size top bit and overrun flag keep the legacy bit positions and function.
// [R13] The baud down-counter reloads at zero or on a divisor low write and ticks at zero.
// [R14] The transmitter divides the tick by 2, 8 or 16 and the receiver uses that many states.
// [R15] The slave transfer clock passes a synchroniser and edge detector, two cycles late.
// [R16] A data port read pops the oldest entry and shows the next entry's status bits.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module ucr_usart_clk_rx (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial pins
  input wire logic rxd_i,
  input wire logic xck_i,
  output logic xck_o,
  output logic xck_oe_o,
  // transmitter base tick and interrupt
  output logic tx_tick_o,
  output logic irq_o
);

  // ==========================================================
  // helpers
  function automatic logic [4:0] spb(input logic sync, input logic dbl);
    if (sync) begin
      return ucr_pkg::SPB_SYNC;
    end else if (dbl) begin
      return ucr_pkg::SPB_DOUBLE;
    end
    return ucr_pkg::SPB_NORMAL;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ==========================================================
  // apb slave
  logic setup_done;
  logic wr_done;
  logic rd_done;
  logic double_speed;
  logic char_size_top;
  logic sync_select;
  logic xck_dir;
  logic [ucr_pkg::BAUD_W-1:0] baud_div;
  logic [ucr_pkg::EV_W-1:0] int_sts;
  logic [ucr_pkg::EV_W-1:0] int_mask;
  logic [ucr_pkg::EV_W-1:0] events;
  logic mapped;
  logic [31:0] rd_mux;
  ucr_pkg::ucr_entry_t head;
  logic head_valid;
  logic q_full;
  logic [1:0] q_count;

  assign setup_done = psel_i && penable_i && !pready_o;
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign rd_done = psel_i && penable_i && pready_o && !pwrite_i;
  assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i[7:2] <= 6'h07);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      // [R12] legacy bit positions
      ucr_pkg::OFF_CTRL_STATUS_A: begin
        rd_mux[ucr_pkg::BIT_RX_COMPLETE] = head_valid;
        rd_mux[ucr_pkg::BIT_FRAME_ERROR] = head_valid && head.frame_err;
        rd_mux[ucr_pkg::BIT_OVERRUN] = head_valid && head.overrun;
        rd_mux[ucr_pkg::BIT_DOUBLE_SPEED] = double_speed;
      end
      ucr_pkg::OFF_CTRL_STATUS_B: begin
        rd_mux[ucr_pkg::BIT_CHAR_SIZE_TOP] = char_size_top;
        rd_mux[ucr_pkg::BIT_NINTH_RX] = head_valid && head.ninth;
      end
      ucr_pkg::OFF_CTRL_STATUS_C: begin
        rd_mux[ucr_pkg::BIT_SYNC_SELECT] = sync_select;
        rd_mux[ucr_pkg::BIT_XCK_DIRECTION] = xck_dir;
      end
      ucr_pkg::OFF_BAUD_LO: rd_mux[7:0] = baud_div[7:0];
      ucr_pkg::OFF_BAUD_HI: rd_mux[3:0] = baud_div[11:8];
      ucr_pkg::OFF_SERIAL_DATA: rd_mux[7:0] = head.data;
      ucr_pkg::OFF_INT_STATUS: rd_mux[ucr_pkg::EV_W-1:0] = int_sts;
      ucr_pkg::OFF_INT_MASK: rd_mux[ucr_pkg::EV_W-1:0] = int_mask;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait state: answer registered in the access phase
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= setup_done;
      prdata_o <= setup_done ? rd_mux : 32'h0000_0000;
      pslverr_o <= setup_done && !mapped;
    end
  end

  // [R8] [R9] control bits
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      double_speed <= ucr_pkg::RST_CTRL_BIT;
      char_size_top <= ucr_pkg::RST_CTRL_BIT;
      sync_select <= ucr_pkg::RST_CTRL_BIT;
      xck_dir <= ucr_pkg::RST_CTRL_BIT;
      baud_div <= ucr_pkg::RST_BAUD;
      int_mask <= ucr_pkg::RST_INT_MASK;
    end else if (wr_done) begin
      case (paddr_i)
        ucr_pkg::OFF_CTRL_STATUS_A: double_speed <= pwdata_i[ucr_pkg::BIT_DOUBLE_SPEED];
        ucr_pkg::OFF_CTRL_STATUS_B: char_size_top <= pwdata_i[ucr_pkg::BIT_CHAR_SIZE_TOP];
        ucr_pkg::OFF_CTRL_STATUS_C: begin
          sync_select <= pwdata_i[ucr_pkg::BIT_SYNC_SELECT];
          xck_dir <= pwdata_i[ucr_pkg::BIT_XCK_DIRECTION];
        end
        ucr_pkg::OFF_BAUD_LO: baud_div[7:0] <= pwdata_i[7:0];
        ucr_pkg::OFF_BAUD_HI: baud_div[11:8] <= pwdata_i[3:0];
        ucr_pkg::OFF_INT_MASK: int_mask <= pwdata_i[ucr_pkg::EV_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_sts <= '0;
      irq_o <= 1'b0;
    end else begin
      int_sts <= (int_sts & ~((wr_done && hit(paddr_i, ucr_pkg::OFF_INT_STATUS)) ?
                 pwdata_i[ucr_pkg::EV_W-1:0] : '0)) | events;
      irq_o <= |(int_sts & int_mask);
    end
  end

  // ==========================================================
  // baud generator and clock modes
  logic [ucr_pkg::BAUD_W-1:0] baud_cnt;
  logic baud_tick;
  logic div_lo_wr;
  logic sync_mode;
  logic master_mode;
  logic slave_mode;
  logic [4:0] states_per_bit;
  logic [4:0] tx_cnt;
  logic xck_s1;
  logic xck_s2;
  logic xck_s3;
  logic slave_rise;
  logic slave_fall;

  // [R8] one selects synchronous
  assign sync_mode = sync_select;
  // [R10] direction picks master or slave
  assign master_mode = sync_mode && xck_dir;
  assign slave_mode = sync_mode && !xck_dir;
  // [R9] double speed ignored when synchronous
  assign states_per_bit = spb(sync_mode, double_speed);
  assign baud_tick = (baud_cnt == '0);
  assign div_lo_wr = wr_done && hit(paddr_i, ucr_pkg::OFF_BAUD_LO);
  assign slave_rise = xck_s2 && !xck_s3;
  assign slave_fall = !xck_s2 && xck_s3;

  // [R13] reload at zero or low write
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      baud_cnt <= ucr_pkg::RST_BAUD;
    end else if (baud_tick || div_lo_wr) begin
      baud_cnt <= div_lo_wr ? {baud_div[11:8], pwdata_i[7:0]} : baud_div;
    end else begin
      baud_cnt <= baud_cnt - 12'h001;
    end
  end

  // [R15] two-stage synchroniser, then edge detect
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_s3 <= 1'b0;
    end else begin
      xck_s1 <= xck_i;
      xck_s2 <= xck_s1;
      xck_s3 <= xck_s2;
    end
  end

  // [R7] [R11] [R14] transmit base tick and master clock
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_cnt <= 5'h00;
      tx_tick_o <= 1'b0;
      xck_o <= 1'b0;
      xck_oe_o <= 1'b0;
    end else begin
      xck_oe_o <= master_mode;
      xck_o <= master_mode ? (xck_o ^ baud_tick) : 1'b0;
      if (slave_mode) begin
        tx_cnt <= 5'h00;
        tx_tick_o <= slave_rise;
      end else if (baud_tick) begin
        tx_cnt <= (tx_cnt >= states_per_bit - 5'h01) ? 5'h00 : tx_cnt + 5'h01;
        tx_tick_o <= (tx_cnt >= states_per_bit - 5'h01);
      end else begin
        tx_tick_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // receiver
  ucr_pkg::ucr_rx_state_t state;
  logic rxd_s1;
  logic rxd_s2;
  logic [4:0] smp_cnt;
  logic [3:0] bit_idx;
  logic [8:0] shift;
  logic frame_err;
  logic pend_dor;
  logic rx_step;
  logic at_point;
  logic push;
  logic pop;
  logic overrun_ev;
  ucr_pkg::ucr_entry_t push_entry;

  // sync sampling at falling clock edge; async on baud ticks
  assign rx_step = slave_mode ? slave_fall : (master_mode ? (baud_tick && xck_o) : baud_tick);
  assign at_point = sync_mode || (smp_cnt == ((state == ucr_pkg::ST_START) ?
                    {1'b0, states_per_bit[4:1]} - 5'h01 : states_per_bit - 5'h01));
  // [R5] parked character enters once room appears
  assign push = (state == ucr_pkg::ST_PARK) && !q_full;
  // [R2] [R16] every data port read pops
  assign pop = rd_done && hit(paddr_i, ucr_pkg::OFF_SERIAL_DATA);
  // [R6] new start bit while full drops the parked one
  // start bit taken on a sample step, as in idle, so sync frames stay aligned
  assign overrun_ev = (state == ucr_pkg::ST_PARK) && q_full && rx_step && !rxd_s2;
  assign events = {push && frame_err, overrun_ev, push};
  // [R3] status travels with the character
  assign push_entry = '{frame_err: frame_err, overrun: pend_dor,
                        ninth: char_size_top && shift[8],
                        data: shift[7:0]};

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
    end else begin
      rxd_s1 <= rxd_i;
      rxd_s2 <= rxd_s1;
    end
  end

  // [R14] recovery counts the same states per bit
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ucr_pkg::ST_IDLE;
      smp_cnt <= 5'h00;
      bit_idx <= 4'h0;
      shift <= 9'h000;
      frame_err <= 1'b0;
    end else begin
      case (state)
        ucr_pkg::ST_IDLE: begin
          smp_cnt <= 5'h00;
          bit_idx <= 4'h0;
          if (rx_step && !rxd_s2) begin
            state <= sync_mode ? ucr_pkg::ST_DATA : ucr_pkg::ST_START;
            shift <= 9'h000;
          end
        end
        ucr_pkg::ST_START: begin
          if (rx_step) begin
            smp_cnt <= at_point ? 5'h00 : smp_cnt + 5'h01;
            // false start filtered at mid-bit
            if (at_point) begin
              state <= rxd_s2 ? ucr_pkg::ST_IDLE : ucr_pkg::ST_DATA;
            end
          end
        end
        ucr_pkg::ST_DATA: begin
          if (rx_step) begin
            smp_cnt <= at_point ? 5'h00 : smp_cnt + 5'h01;
            if (at_point) begin
              shift[bit_idx] <= rxd_s2;
              bit_idx <= bit_idx + 4'h1;
              if (bit_idx == (char_size_top ? ucr_pkg::LAST_BIT_9 : ucr_pkg::LAST_BIT_8)) begin
                state <= ucr_pkg::ST_STOP;
              end
            end
          end
        end
        ucr_pkg::ST_STOP: begin
          if (rx_step) begin
            smp_cnt <= at_point ? 5'h00 : smp_cnt + 5'h01;
            if (at_point) begin
              frame_err <= !rxd_s2;
              state <= ucr_pkg::ST_PARK;
            end
          end
        end
        ucr_pkg::ST_PARK: begin
          smp_cnt <= 5'h00;
          bit_idx <= 4'h0;
          if (push) begin
            state <= ucr_pkg::ST_IDLE;
          end else if (overrun_ev) begin
            state <= sync_mode ? ucr_pkg::ST_DATA : ucr_pkg::ST_START;
            shift <= 9'h000;
          end
        end
        default: state <= ucr_pkg::ST_IDLE;
      endcase
    end
  end

  // lost character is flagged on the next one stored
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_dor <= 1'b0;
    end else if (overrun_ev) begin
      pend_dor <= 1'b1;
    end else if (push) begin
      pend_dor <= 1'b0;
    end
  end

  ucr_rx_queue u_queue (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .push_i(push),
    .push_entry_i(push_entry),
    .pop_i(pop),
    .head_o(head),
    .head_valid_o(head_valid),
    .full_o(q_full),
    .count_o(q_count)
  );

  // ==========================================================
  // assertions
  sequence s_read_pop;
    pop && q_count != 2'h0;
  endsequence

  AST_BAUD_RELOAD: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (baud_tick && !div_lo_wr) |=> baud_cnt == $past(baud_div)) // [R13]
    else $error("baud counter did not reload");
  AST_XCK_OE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    xck_oe_o == $past(sync_select && xck_dir)) // [R10]
    else $error("transfer clock enable wrong");
  AST_XCK_ASYNC_IDLE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (!sync_select)[*2] |-> !xck_oe_o && !xck_o) // [R11]
    else $error("transfer clock active in async mode");
  AST_SLAVE_DELAY: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (slave_mode && $rose(xck_s1)) ##1 slave_mode |-> slave_rise) // [R15]
    else $error("slave clock edge not seen two cycles late");
  AST_POP_ADVANCE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    s_read_pop ##0 !push |=> q_count == $past(q_count) - 2'h1) // [R16]
    else $error("data read did not pop queue");
  AST_PARK_HOLD: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (state == ucr_pkg::ST_PARK && q_full && rxd_s2) |=> state == ucr_pkg::ST_PARK) // [R6]
    else $error("parked character left early");
  AST_OVERRUN_MARK: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    overrun_ev |=> pend_dor && int_sts[ucr_pkg::BIT_EV_OVERRUN]) // [R6]
    else $error("overrun not recorded");
  AST_DBL_ASYNC_ONLY: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    sync_mode |-> states_per_bit == ucr_pkg::SPB_SYNC) // [R9]
    else $error("double speed leaked into sync mode");
  AST_IRQ_LEVEL: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    ##1 irq_o == |($past(int_sts) & $past(int_mask)))
    else $error("interrupt level wrong");

endmodule

// ===== ucr_usart_clk_rx_tb.sv
// ucr_usart_clk_rx_tb: self-checking bench for the clock modes and receive store.
// assumes ucr_pkg, the design and ucr_serial_node are compiled first.
`timescale 1ns/1ps
module ucr_usart_clk_rx_tb;
  logic ref_clk_i = 1'b0;
  logic arst_n_i, psel_i, penable_i, pwrite_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic pready_o, pslverr_o, rxd_i, xck_i, xck_o, xck_oe_o, tx_tick_o, irq_o, err;
  logic [8:0] c [4];
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  int g;
  int sp [4] = '{16, 8, 2, 2};
  logic [2:0] md [4] = '{3'b000, 3'b100, 3'b111, 3'b011};

  always #5 ref_clk_i = ~ref_clk_i;

  ucr_usart_clk_rx i_ucr_usart_clk_rx (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .rxd_i(rxd_i), .xck_i(xck_i), .xck_o(xck_o), .xck_oe_o(xck_oe_o),
    .tx_tick_o(tx_tick_o), .irq_o(irq_o));
  ucr_serial_node i_ucr_serial_node (.ref_clk_i(ref_clk_i), .xck_i(xck_o),
    .rxd_o(rxd_i), .xck_o(xck_i));

  // ==========================================================
  // report and hang guard
  task automatic stop_test();
    $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  // ==========================================================
  // apb master
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  function automatic logic [31:0] fa(logic v, logic fe, logic ov, logic ds);
    fa = 32'h0;
    fa[ucr_pkg::BIT_RX_COMPLETE] = v;
    fa[ucr_pkg::BIT_FRAME_ERROR] = fe;
    fa[ucr_pkg::BIT_OVERRUN] = ov;
    fa[ucr_pkg::BIT_DOUBLE_SPEED] = ds;
  endfunction

  task automatic cfg(input logic ds, input logic sy, input logic dir, input logic [11:0] d);
    apb(1'b1, ucr_pkg::OFF_CTRL_STATUS_A, 32'(ds) << ucr_pkg::BIT_DOUBLE_SPEED);
    apb(1'b1, ucr_pkg::OFF_CTRL_STATUS_C, (32'(sy) << ucr_pkg::BIT_SYNC_SELECT) | 32'(dir));
    apb(1'b1, ucr_pkg::OFF_BAUD_HI, 32'(d[11:8]));
    apb(1'b1, ucr_pkg::OFF_BAUD_LO, 32'(d[7:0]));
  endtask

  // first gap after a mode change may be short, so callers measure twice
  task automatic gap_of(output int n);
    n = 0;
    do @(posedge ref_clk_i); while (tx_tick_o !== 1'b1);
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (tx_tick_o !== 1'b1);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {arst_n_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    void'($urandom(32'h5a44));
    for (int i = 0; i < 4; i++) c[i] = 9'($urandom);
    repeat (8) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    rdchk(ucr_pkg::OFF_CTRL_STATUS_A, 32'h0, "ctrl_a_rst");
    rdchk(ucr_pkg::OFF_CTRL_STATUS_C, 32'h0, "ctrl_c_rst");
    rdchk(ucr_pkg::OFF_INT_MASK, 32'h0, "mask_rst");
    rdchk(8'h20, 32'h0, "unmapped_rd");
    chk("unmapped_err", 32'h1, 32'(err));
    chk("irq_rst", 32'h0, 32'(irq_o));
    for (int i = 0; i < 4; i++) begin
      cfg(md[i][2], md[i][1], md[i][0], 12'h001);
      gap_of(g);
      gap_of(g);
      chk("tick_gap", 32'(sp[i] * 2), 32'(g));
      chk("xck_oe", 32'(md[i][1] & md[i][0]), 32'(xck_oe_o));
    end
    cfg(1'b0, 1'b0, 1'b0, 12'h000);
    apb(1'b1, ucr_pkg::OFF_INT_MASK, 32'h2);
    for (int i = 0; i < 4; i++) i_ucr_serial_node.send(c[i], 8, 1'b1, 0, 8);
    repeat (6) @(posedge ref_clk_i);
    chk("irq_overrun", 32'h1, 32'(irq_o));
    // status first, then one data read per stored character
    rdchk(ucr_pkg::OFF_CTRL_STATUS_A, fa(1, 0, 0, 0), "st0");
    rdchk(ucr_pkg::OFF_SERIAL_DATA, {24'h0, c[0][7:0]}, "data0");
    rdchk(ucr_pkg::OFF_CTRL_STATUS_A, fa(1, 0, 0, 0), "st1");
    rdchk(ucr_pkg::OFF_SERIAL_DATA, {24'h0, c[1][7:0]}, "data1");
    rdchk(ucr_pkg::OFF_CTRL_STATUS_A, fa(1, 0, 1, 0), "st3");
    rdchk(ucr_pkg::OFF_SERIAL_DATA, {24'h0, c[3][7:0]}, "data3");
    rdchk(ucr_pkg::OFF_INT_STATUS, 32'h3, "int_st");
    apb(1'b1, ucr_pkg::OFF_INT_STATUS, 32'h2);
    repeat (2) @(posedge ref_clk_i);
    chk("irq_clear", 32'h0, 32'(irq_o));
    rdchk(ucr_pkg::OFF_INT_STATUS, 32'h1, "int_w1c");
    // nine bits, double speed, broken stop bit
    apb(1'b1, ucr_pkg::OFF_CTRL_STATUS_B, 32'h4);
    cfg(1'b1, 1'b0, 1'b0, 12'h000);
    i_ucr_serial_node.send(c[2], 9, 1'b0, 0, 4);
    repeat (6) @(posedge ref_clk_i);
    rdchk(ucr_pkg::OFF_CTRL_STATUS_B, {29'h0, 1'b1, c[2][8], 1'b0}, "ninth");
    rdchk(ucr_pkg::OFF_CTRL_STATUS_A, fa(1, 1, 0, 1), "fe");
    rdchk(ucr_pkg::OFF_SERIAL_DATA, {24'h0, c[2][7:0]}, "data_ds");
    apb(1'b1, ucr_pkg::OFF_CTRL_STATUS_B, 32'h0);
    // master sync with double speed set, which must be ignored
    cfg(1'b1, 1'b1, 1'b1, 12'h003);
    i_ucr_serial_node.send(c[1], 8, 1'b1, 2, 4);
    repeat (6) @(posedge ref_clk_i);
    rdchk(ucr_pkg::OFF_SERIAL_DATA, {24'h0, c[1][7:0]}, "data_master");
    cfg(1'b0, 1'b1, 1'b0, 12'h000);
    chk("xck_slave", 32'h0, 32'({xck_o, xck_oe_o}));
    i_ucr_serial_node.send(c[0], 8, 1'b1, 1, 4);
    repeat (6) @(posedge ref_clk_i);
    rdchk(ucr_pkg::OFF_SERIAL_DATA, {24'h0, c[0][7:0]}, "data_slave");
    stop_test();
  end
endmodule
